/* File: logic/acl_staging_pkg.sv */
package acl_staging_pkg;

    // Bus geometry: registers sit one per word, byte address = index * 4
    localparam int ADDR_W = 13;
    localparam int INDEX_W = 11;
    localparam int STAGE_BYTES = 16;
    localparam int TABLE_ENTRIES = 16;

    // Register indices
    localparam logic [INDEX_W-1:0] IDX_RULE_FIRST_NUMBER = 11'h600;
    localparam logic [INDEX_W-1:0] IDX_RULE_MODE_CTRL = 11'h601;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE5 = 11'h602;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE4 = 11'h603;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE3 = 11'h604;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE2 = 11'h605;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE1 = 11'h606;
    localparam logic [INDEX_W-1:0] IDX_MATCH_MAC_BYTE0 = 11'h607;
    localparam logic [INDEX_W-1:0] IDX_MATCH_ETHERTYPE_HIGH = 11'h608;
    localparam logic [INDEX_W-1:0] IDX_MATCH_ETHERTYPE_LOW = 11'h609;
    localparam logic [INDEX_W-1:0] IDX_ACTION_PRIORITY_CTRL = 11'h60a;
    localparam logic [INDEX_W-1:0] IDX_ACTION_REMARK_MAP = 11'h60b;
    localparam logic [INDEX_W-1:0] IDX_ACTION_SPARE_BYTE = 11'h60c;
    localparam logic [INDEX_W-1:0] IDX_ACTION_FORWARD_PORTS = 11'h60d;
    localparam logic [INDEX_W-1:0] IDX_RULESET_MASK_HIGH = 11'h60e;
    localparam logic [INDEX_W-1:0] IDX_RULESET_MASK_LOW = 11'h60f;
    localparam logic [INDEX_W-1:0] IDX_STAGING_BYTE_SELECT_HIGH = 11'h610;
    localparam logic [INDEX_W-1:0] IDX_STAGING_BYTE_SELECT_LOW = 11'h611;
    localparam logic [INDEX_W-1:0] IDX_ENTRY_CONTROL = 11'h612;

    // Staging byte slots within one entry
    localparam int SLOT_MODE = 1;
    localparam int SLOT_MAC_FIRST = 2;
    localparam int SLOT_ETYPE_HIGH = 8;
    localparam int SLOT_ETYPE_LOW = 9;
    localparam int SLOT_PRIO_CTRL = 10;
    localparam int SLOT_REMARK_MAP = 11;
    localparam int SLOT_FORWARD = 13;
    localparam int SLOT_RULESET_HIGH = 14;
    localparam int SLOT_RULESET_LOW = 15;

    // Field positions
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 4;
    localparam int PRIO_KIND_HI = 7;
    localparam int PRIO_KIND_LO = 6;
    localparam int PRIO_HI = 5;
    localparam int PRIO_LO = 3;
    localparam int REMARK_EN_BIT = 2;
    localparam int REMARK_UPPER_HI = 1;
    localparam int REMARK_LOWER_BIT = 7;
    localparam int MAP_KIND_HI = 6;
    localparam int MAP_KIND_LO = 5;
    localparam int FORWARD_HI = 6;
    localparam int CTRL_WRITE_DONE = 6;
    localparam int CTRL_READ_DONE = 5;
    localparam int CTRL_DIR = 4;

    // Reset values
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic DONE_RESET = 1'b1;

    typedef enum logic [1:0] {
        MATCH_NONE = 2'b00,
        MATCH_L2_MAC = 2'b01,
        MATCH_L3_IP = 2'b10,
        MATCH_L4_PORT = 2'b11
    } match_kind_t;

    typedef enum logic {
        XFER_IDLE = 1'b0,
        XFER_MOVE = 1'b1
    } xfer_state_t;

endpackage : acl_staging_pkg

/* File: logic/acl_entry_staging_regs.sv */
module acl_entry_staging_regs
    import acl_staging_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acl_staging_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Rule lookup by the matching datapath
    input wire logic [3:0] lookup_index,
    output acl_staging_pkg::match_kind_t lookup_match_kind,
    output logic [47:0] lookup_mac,
    output logic [15:0] lookup_ethertype,
    output logic [1:0] lookup_priority_select_kind,
    output logic [2:0] lookup_priority,
    output logic lookup_remark_enable_flag,
    output logic [2:0] lookup_remark_priority,
    output logic [1:0] lookup_forward_map_kind,
    output logic [6:0] lookup_forward_ports,
    output logic [15:0] lookup_ruleset
);
    import acl_staging_pkg::*;

    logic [STAGE_BYTES-1:0][7:0] staging_reg;
    logic [STAGE_BYTES-1:0][7:0] staging_next;
    logic [STAGE_BYTES-1:0][7:0] table_mem [TABLE_ENTRIES];
    logic [STAGE_BYTES-1:0][7:0] merged_entry;
    logic [7:0] sel_high_reg;
    logic [7:0] sel_low_reg;
    logic [3:0] entry_index_reg;
    logic write_dir_reg;
    logic read_done_reg;
    logic write_done_reg;
    logic [31:0] prdata_reg;
    xfer_state_t state_reg;
    xfer_state_t state_next;
    logic [STAGE_BYTES-1:0] byte_en;

    // Address decode
    wire [INDEX_W-1:0] reg_index = paddr[ADDR_W-1:2];
    wire [3:0] stage_slot = reg_index[3:0];
    wire aligned = (paddr[1:0] == 2'b00);
    wire in_staging = (reg_index[INDEX_W-1:4] == IDX_RULE_FIRST_NUMBER[INDEX_W-1:4]);
    wire hit_sel_high = (reg_index == IDX_STAGING_BYTE_SELECT_HIGH);
    wire hit_sel_low = (reg_index == IDX_STAGING_BYTE_SELECT_LOW);
    wire hit_ctrl = (reg_index == IDX_ENTRY_CONTROL);
    wire mapped = aligned & (in_staging | hit_sel_high | hit_sel_low | hit_ctrl);
    wire apb_setup = psel & ~penable;
    wire apb_access = psel & penable;
    wire wr_en = apb_access & pwrite & mapped & pstrb[0];
    wire start = wr_en & hit_sel_low;
    wire xfer_active = (state_reg == XFER_MOVE);
    wire xfer_read = xfer_active & ~write_dir_reg;
    wire xfer_write = xfer_active & write_dir_reg;
    wire [15:0] byte_sel = {sel_high_reg, sel_low_reg};
    wire [STAGE_BYTES-1:0][7:0] cur_entry = table_mem[entry_index_reg];
    wire [STAGE_BYTES-1:0][7:0] lookup_row = table_mem[lookup_index];
    wire [7:0] ctrl_value = {1'b0, write_done_reg, read_done_reg, write_dir_reg, entry_index_reg};
    wire [7:0] rd_byte = !mapped ? 8'h00 : in_staging ? staging_reg[stage_slot] :
                         hit_sel_high ? sel_high_reg :
                         hit_sel_low ? sel_low_reg :
                         hit_ctrl ? ctrl_value : 8'h00;

    assign pready = 1'b1;
    assign pslverr = apb_access & ~mapped;
    assign prdata = prdata_reg;

    // Per-byte select order, merge and staging update
    genvar k;
    generate
        for (k = 0; k < STAGE_BYTES; k++) begin : g_byte
            assign byte_en[k] = byte_sel[STAGE_BYTES-1-k];
            assign merged_entry[k] = byte_en[k] ? staging_reg[k] : cur_entry[k];
            assign staging_next[k] =
                (wr_en && in_staging && stage_slot == 4'(k)) ? pwdata[7:0] :
                (xfer_read && byte_en[k]) ? cur_entry[k] : staging_reg[k];
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            XFER_IDLE: begin
                if (start) begin
                    state_next = XFER_MOVE;
                end
            end
            XFER_MOVE: begin
                state_next = XFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= XFER_IDLE;
            staging_reg <= {STAGE_BYTES{STAGE_RESET}};
        end else begin
            state_reg <= state_next;
            staging_reg <= staging_next;
        end
    end

    // Table entry write-back of the selected bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int e = 0; e < TABLE_ENTRIES; e++) begin
                table_mem[e] <= {STAGE_BYTES{STAGE_RESET}};
            end
        end else if (xfer_write) begin
            table_mem[entry_index_reg] <= merged_entry;
        end
    end

    // Select registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_high_reg <= SELECT_RESET;
            sel_low_reg <= SELECT_RESET;
        end else begin
            if (wr_en && hit_sel_high) begin
                sel_high_reg <= pwdata[7:0];
            end
            if (wr_en && hit_sel_low) begin
                sel_low_reg <= pwdata[7:0];
            end
        end
    end

    // Index, direction and completion flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_index_reg <= INDEX_RESET;
            write_dir_reg <= 1'b0;
            read_done_reg <= DONE_RESET;
            write_done_reg <= DONE_RESET;
        end else begin
            if (wr_en && hit_ctrl) begin
                entry_index_reg <= pwdata[3:0];
                write_dir_reg <= pwdata[CTRL_DIR];
            end
            if (start && !write_dir_reg) begin
                read_done_reg <= 1'b0;
            end else if (xfer_read) begin
                read_done_reg <= 1'b1;
            end
            if (start && write_dir_reg) begin
                write_done_reg <= 1'b0;
            end else if (xfer_write) begin
                write_done_reg <= 1'b1;
            end
        end
    end

    // Read data captured in the setup cycle, valid through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Decoded rule fields for the matching datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lookup_match_kind <= MATCH_NONE;
            lookup_mac <= 48'h0000_0000_0000;
            lookup_ethertype <= 16'h0000;
            lookup_priority_select_kind <= 2'h0;
            lookup_priority <= 3'h0;
            lookup_remark_enable_flag <= 1'b0;
            lookup_remark_priority <= 3'h0;
            lookup_forward_map_kind <= 2'h0;
            lookup_forward_ports <= 7'h00;
            lookup_ruleset <= 16'h0000;
        end else begin
            lookup_match_kind <= match_kind_t'(lookup_row[SLOT_MODE][MODE_HI:MODE_LO]);
            lookup_mac <= {lookup_row[SLOT_MAC_FIRST], lookup_row[SLOT_MAC_FIRST+1],
                           lookup_row[SLOT_MAC_FIRST+2], lookup_row[SLOT_MAC_FIRST+3],
                           lookup_row[SLOT_MAC_FIRST+4], lookup_row[SLOT_MAC_FIRST+5]};
            lookup_ethertype <= {lookup_row[SLOT_ETYPE_HIGH], lookup_row[SLOT_ETYPE_LOW]};
            lookup_priority_select_kind <= lookup_row[SLOT_PRIO_CTRL][PRIO_KIND_HI:PRIO_KIND_LO];
            lookup_priority <= lookup_row[SLOT_PRIO_CTRL][PRIO_HI:PRIO_LO];
            lookup_remark_enable_flag <= lookup_row[SLOT_PRIO_CTRL][REMARK_EN_BIT];
            lookup_remark_priority <= {lookup_row[SLOT_PRIO_CTRL][REMARK_UPPER_HI:0],
                                       lookup_row[SLOT_REMARK_MAP][REMARK_LOWER_BIT]};
            lookup_forward_map_kind <= lookup_row[SLOT_REMARK_MAP][MAP_KIND_HI:MAP_KIND_LO];
            lookup_forward_ports <= lookup_row[SLOT_FORWARD][FORWARD_HI:0];
            lookup_ruleset <= {lookup_row[SLOT_RULESET_HIGH], lookup_row[SLOT_RULESET_LOW]};
        end
    end

    // Checks
    a_high_sel_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_read && sel_high_reg[7]) |=> staging_reg[0] == $past(cur_entry[0]))
        else $error("High select bit 7 did not load staging byte 0");

    a_high_sel_last: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_read && sel_high_reg[0]) |=> staging_reg[7] == $past(cur_entry[7]))
        else $error("High select bit 0 did not load staging byte 7");

    a_low_sel_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_write && sel_low_reg[0]) |=> cur_entry[15] == $past(staging_reg[15]))
        else $error("Low select bit 0 did not store staging byte 15");

    a_low_sel_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_read && sel_low_reg[7]) |=> staging_reg[8] == $past(cur_entry[8]))
        else $error("Low select bit 7 did not load staging byte 8");

    a_start_one_move: assert property (
        @(posedge pclk) disable iff (!presetn)
        start |=> xfer_active ##1 !xfer_active)
        else $error("Low select write did not run exactly one transfer cycle");

    a_staging_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_read && !byte_en[3]) |=> $stable(staging_reg[3]))
        else $error("Unselected staging byte changed on a table read");

    a_table_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_write && !byte_en[12]) |=> $stable(cur_entry[12]))
        else $error("Unselected table byte changed on a table write");

    a_forward_map: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 lookup_forward_ports == $past(lookup_row[SLOT_FORWARD][FORWARD_HI:0]))
        else $error("Forward map does not follow the entry");

    a_remark_split: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 (lookup_remark_priority[2:1] == $past(lookup_row[SLOT_PRIO_CTRL][1:0]))
            && (lookup_remark_priority[0] == $past(lookup_row[SLOT_REMARK_MAP][7])))
        else $error("Remark priority assembled from wrong bits");

    a_mac_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 (lookup_mac[47:40] == $past(lookup_row[SLOT_MAC_FIRST]))
            && (lookup_ethertype[7:0] == $past(lookup_row[SLOT_ETYPE_LOW])))
        else $error("MAC or EtherType byte order wrong");

    a_read_flag_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (start && !write_dir_reg) |=> !read_done_reg ##1 read_done_reg)
        else $error("Read-complete flag not low for exactly the transfer cycle");

    a_match_kind: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 lookup_match_kind == match_kind_t'($past(lookup_row[SLOT_MODE][MODE_HI:MODE_LO])))
        else $error("Match kind does not follow the mode field");

    a_sel_high_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sel_high) |=> sel_high_reg == $past(pwdata[7:0]))
        else $error("High select register did not take the written byte");

    a_sel_low_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sel_low) |=> sel_low_reg == $past(pwdata[7:0]))
        else $error("Low select register did not take the written byte");

    a_move_after_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        xfer_active |-> $past(start))
        else $error("Transfer cycle without a low select write");

    a_write_flag_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_done_reg == !xfer_write)
        else $error("Write-complete flag not low exactly in the write cycle");

    a_read_flag_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        read_done_reg == !xfer_read)
        else $error("Read-complete flag not low exactly in the read cycle");

    a_read_keeps_table: assert property (
        @(posedge pclk) disable iff (!presetn)
        xfer_read |=> $stable(cur_entry))
        else $error("Table entry changed on a table read");

    a_write_keeps_stage: assert property (
        @(posedge pclk) disable iff (!presetn)
        xfer_write |=> $stable(staging_reg))
        else $error("Staging bytes changed on a table write");

    a_high_sel_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_write && sel_high_reg[0]) |=> cur_entry[7] == $past(staging_reg[7]))
        else $error("High select bit 0 did not store staging byte 7");

    a_high_sel_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_write && !sel_high_reg[7]) |=> $stable(cur_entry[0]))
        else $error("Table byte 0 changed with high select bit 7 clear");

    a_low_sel_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_read && !sel_low_reg[0]) |=> $stable(staging_reg[15]))
        else $error("Staging byte 15 changed with low select bit 0 clear");

    a_low_write_skip: assert property (
        @(posedge pclk) disable iff (!presetn)
        (xfer_write && !sel_low_reg[7]) |=> $stable(cur_entry[8]))
        else $error("Table byte 8 changed with low select bit 7 clear");

    a_forward_port_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 lookup_forward_ports[0] == $past(lookup_row[13][0]))
        else $error("Port 1 forward bit not taken from bit 0 of byte 13");

    a_remark_enable: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 lookup_remark_enable_flag == $past(lookup_row[10][2]))
        else $error("Remark enable not taken from bit 2 of byte 10");

    a_ethertype_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 lookup_ethertype[15:8] == $past(lookup_row[8]))
        else $error("EtherType high byte not taken from byte 8");

endmodule : acl_entry_staging_regs

/* File: verification/acl_entry_staging_regs_tb.sv */
module acl_entry_staging_regs_tb
    import acl_staging_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] lookup_index;
    match_kind_t lookup_match_kind;
    logic [47:0] lookup_mac;
    logic [15:0] lookup_ethertype;
    logic [1:0] lookup_priority_select_kind;
    logic [2:0] lookup_priority;
    logic lookup_remark_enable_flag;
    logic [2:0] lookup_remark_priority;
    logic [1:0] lookup_forward_map_kind;
    logic [6:0] lookup_forward_ports;
    logic [15:0] lookup_ruleset;
    int err_total;
    int tests_run;
    logic last_err;
    logic [7:0] stage [16];

    acl_entry_staging_regs acl_entry_staging_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lookup_index(lookup_index), .lookup_match_kind(lookup_match_kind),
        .lookup_mac(lookup_mac), .lookup_ethertype(lookup_ethertype),
        .lookup_priority_select_kind(lookup_priority_select_kind),
        .lookup_priority(lookup_priority), .lookup_remark_enable_flag(lookup_remark_enable_flag),
        .lookup_remark_priority(lookup_remark_priority),
        .lookup_forward_map_kind(lookup_forward_map_kind),
        .lookup_forward_ports(lookup_forward_ports), .lookup_ruleset(lookup_ruleset)
    );

    always #12.5 pclk = ~pclk;

    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [INDEX_W-1:0] idx, input logic [7:0] d,
                       output logic [7:0] rd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        pstrb <= wr ? 4'hf : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [INDEX_W-1:0] idx, input logic [7:0] d);
        logic [7:0] rd;
        apb(1'b1, idx, d, rd);
    endtask : wr

    task automatic rd_chk(input string what, input logic [INDEX_W-1:0] idx, input logic [7:0] exp);
        logic [7:0] rd;
        apb(1'b0, idx, 8'h00, rd);
        check(what, 64'(rd), 64'(exp));
    endtask : rd_chk

    // Start a table move and poll the matching done flag
    task automatic xfer(input logic [7:0] hi, input logic [7:0] ctrl, input logic [7:0] lo);
        logic [7:0] rd;
        int n;
        int b;
        b = ctrl[CTRL_DIR] ? CTRL_WRITE_DONE : CTRL_READ_DONE;
        wr(IDX_STAGING_BYTE_SELECT_HIGH, hi);
        wr(IDX_ENTRY_CONTROL, ctrl);
        wr(IDX_STAGING_BYTE_SELECT_LOW, lo);
        n = 0;
        do begin
            apb(1'b0, IDX_ENTRY_CONTROL, 8'h00, rd);
            n++;
        end while (rd[b] !== 1'b1 && n < 20);
        check("done flag", 64'(rd[b]), 64'h1);
        if (rd[b] !== 1'b1) begin
            end_sim();
        end
    endtask : xfer

    task automatic look(input logic [3:0] idx);
        lookup_index <= idx;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : look

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        lookup_index = 4'h0;
        err_total = 0;
        tests_run = 0;
        stage = '{8'h00, 8'h10, 8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab,
                  8'h88, 8'hf7, 8'hb6, 8'hc0, 8'h5a, 8'h55, 8'h3c, 8'hc3};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;

        for (int k = 0; k < 18; k++) begin
            rd_chk("staging reset", INDEX_W'(IDX_RULE_FIRST_NUMBER + k), 8'h00);
        end
        rd_chk("control reset", IDX_ENTRY_CONTROL, 8'h60);
        check("mapped no error", 64'(last_err), 64'h0);
        rd_chk("unmapped read", 11'h613, 8'h00);
        check("unmapped error", 64'(last_err), 64'h1);
        look(4'h0);
        check("lookup mac reset", 64'(lookup_mac), 64'h0);
        $display("Test reset values done");

        for (int k = 1; k < 16; k++) begin
            wr(INDEX_W'(IDX_RULE_FIRST_NUMBER + k), stage[k]);
        end
        xfer(8'h7f, 8'h13, 8'hff);
        look(4'h3);
        check("match kind", 64'(lookup_match_kind), 64'(MATCH_L2_MAC));
        check("mac", 64'(lookup_mac), 64'h0123456789ab);
        check("ethertype", 64'(lookup_ethertype), 64'h88f7);
        check("prio kind", 64'(lookup_priority_select_kind), 64'h2);
        check("prio", 64'(lookup_priority), 64'h6);
        check("remark en", 64'(lookup_remark_enable_flag), 64'h1);
        check("remark prio", 64'(lookup_remark_priority), 64'h5);
        check("map kind", 64'(lookup_forward_map_kind), 64'h2);
        check("forward", 64'(lookup_forward_ports), 64'h55);
        check("ruleset", 64'(lookup_ruleset), 64'h3cc3);
        $display("Test full entry write done");

        wr(IDX_RULESET_MASK_HIGH, 8'h77);
        wr(IDX_RULESET_MASK_LOW, 8'h99);
        xfer(8'h00, 8'h13, 8'h01);
        look(4'h3);
        check("ruleset partial", 64'(lookup_ruleset), 64'h3c99);
        $display("Test partial write done");

        wr(IDX_MATCH_MAC_BYTE5, 8'hee);
        wr(IDX_MATCH_MAC_BYTE0, 8'hee);
        wr(IDX_MATCH_ETHERTYPE_HIGH, 8'hee);
        wr(IDX_RULE_FIRST_NUMBER, 8'hee);
        xfer(8'h81, 8'h03, 8'h80);
        rd_chk("byte 0 read", IDX_RULE_FIRST_NUMBER, 8'h00);
        rd_chk("byte 7 read", IDX_MATCH_MAC_BYTE0, 8'hab);
        rd_chk("byte 8 read", IDX_MATCH_ETHERTYPE_HIGH, 8'h88);
        rd_chk("byte 2 kept", IDX_MATCH_MAC_BYTE5, 8'hee);
        rd_chk("byte 14 kept", IDX_RULESET_MASK_HIGH, 8'h77);
        $display("Test partial read done");

        for (int m = 0; m < 4; m++) begin
            wr(IDX_RULE_MODE_CTRL, {2'b00, 2'(m), 4'h0});
            xfer(8'h40, 8'(8'h14 + m), 8'h00);
            look(4'(4 + m));
            check("mode", 64'(lookup_match_kind), 64'(m));
            check("mac untouched", 64'(lookup_mac), 64'h0);
        end
        $display("Test match modes done");
        end_sim();
    end

    initial begin
        #2ms;
        err_total++;
        end_sim();
    end
endmodule : acl_entry_staging_regs_tb
